// File: inc/dac_defines.svh
// Offsets, field positions, codes and reset values of the channel register
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH

`define DAC_CTRL_STATUS_OFS 4'h0
`define DAC_BIT_FLAG 15
`define DAC_BIT_IL_HI 14
`define DAC_BIT_IL_LO 12
`define DAC_BIT_ARB3 11
`define DAC_BIT_WOR 9
`define DAC_BIT_BSL 8
`define DAC_BIT_IN 7
`define DAC_BIT_FORCE_A 6
`define DAC_BIT_FORCE_B 5
`define DAC_BIT_POL 4
`define DAC_BIT_MODE_HI 3
`define DAC_BIT_MODE_LO 0

`define DAC_MODE_DIS 4'h0
`define DAC_MODE_PULSE_WIDTH_MEASURE_MODE 4'h1
`define DAC_MODE_IPM 4'h2
`define DAC_MODE_IC 4'h3
`define DAC_MODE_OCB 4'h4
`define DAC_MODE_COMPARE_AB_FLAG_MODE 4'h5

`define DAC_RST_IL 3'h0
`define DAC_RST_MODE 4'h0

`endif

// File: inc/dac_pkg.sv
// Types shared by the capture/compare channel control block
package dac_pkg;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dac_bus_req_type;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } dac_pin_drive_type;

  typedef struct packed {
    logic irq;
    logic [2:0] level;
    logic [3:0] arb_number;
  } dac_irq_type;

endpackage

// File: logic/dac_channel_ctrl.sv
// Control/status register and event logic of one dual-action channel
// Operation
// R1: Capture or compare events set the flag; flag with level nonzero requests
// R2: Disabled clears flag; capture A sets it; period mode skips first capture
// R3: Compare B, compare A or B, or PWM A match set the flag
// R4: Only hardware sets flag; reset, disabled, or read-one-write-zero clear it
// R5: Level field picks request line; zero disables; ack compares level
// R6: Arbitration number is arbitration bit above the module config field
// R7: In output modes wired-or bit selects push-pull or open-drain drive
// R8: In other modes wired-or bit does nothing but reads back
// R9: Bus select zero picks time base bus A, one picks bus B
// R10: In disabled and input modes pin status shows the pin level
// R11: In output modes pin status shows latched output after polarity
// R12: Force A write acts like channel A match without setting flag
// R13: Force B write acts like channel B match without setting flag
// R14: Both force bits written together reset the output flip-flop
// R15: Force bits read zero, reset clear, ignored outside output modes
// R16: Pulse-width mode polarity zero: A rising, B falling; one reverses
// R17: Period and capture modes: A captures rising, or falling with polarity
// R18: Output modes: A match drives high, B low; polarity inverts
// R19: Mode field encodes six modes, two unused, eight PWM resolutions
// R20: Software should disable interrupts before changing mode
// R21: Fields reset to zero; pin status follows pin; unused bit reads zero
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`include "dac_defines.svh"

module dac_channel_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire dac_pkg::dac_bus_req_type bus_req_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // Channel pin
  input wire logic pin_in,
  output dac_pkg::dac_pin_drive_type pin_drive_out,
  // Comparator matches and capture strobes
  input wire logic match_a_in,
  input wire logic match_b_in,
  output logic capture_a_out,
  output logic capture_b_out,
  // Time base selection
  output logic bus_select_out,
  output logic [15:0] timebase_mask_out,
  // Interrupt side
  input wire logic [2:0] arb_low_field_in,
  input wire logic iack_in,
  input wire logic [2:0] iack_level_in,
  output dac_pkg::dac_irq_type irq_out,
  output logic iack_respond_out
);
  import dac_pkg::*;

  logic flag_r;
  logic [2:0] interrupt_level_r;
  logic arbitration_msb_r;
  logic wired_or_r;
  logic bus_select_r;
  logic polarity_select_r;
  logic [3:0] mode_r;
  logic out_ff_r;
  logic pin_prev_r;
  logic flag_read_one_r;
  logic ipm_first_done_r;
  logic wait_r;

  logic bus_hit;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] wr_data;
  logic [15:0] rd_word;
  logic out_mode;
  logic in_mode;
  logic rise;
  logic fall;
  logic cap_a;
  logic cap_b;
  logic force_a;
  logic force_b;
  logic flag_set;
  logic flag_clr;
  logic pin_level;
  logic [15:0] ignore_mask;

  function automatic logic is_output_mode(input logic [3:0] m);
    is_output_mode = m[3] || (m == `DAC_MODE_OCB) || (m == `DAC_MODE_COMPARE_AB_FLAG_MODE);
  endfunction

  function automatic logic is_input_mode(input logic [3:0] m);
    is_input_mode = (m == `DAC_MODE_PULSE_WIDTH_MEASURE_MODE) || (m == `DAC_MODE_IPM) ||
                    (m == `DAC_MODE_IC);
  endfunction

  // Time base bits ignored for each PWM resolution
  function automatic logic [15:0] pwm_ignore(input logic [3:0] m);
    logic [15:0] r;
    r = 16'h0000;
    unique case (m)
      4'h9: r = 16'h8000;
      4'ha: r = 16'hc000;
      4'hb: r = 16'he000;
      4'hc: r = 16'hf000;
      4'hd: r = 16'hf800;
      4'he: r = 16'hfe00;
      4'hf: r = 16'hff80;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  assign out_mode = is_output_mode(mode_r);
  assign in_mode = is_input_mode(mode_r);
  assign ignore_mask = pwm_ignore(mode_r); // R19

  // Bus decode: a request completes on the edge where waitrequest is low
  assign bus_hit = bus_req_in.address == `DAC_CTRL_STATUS_OFS;
  assign wr_acc = bus_req_in.write && !wait_r && bus_hit;
  assign rd_acc = bus_req_in.read && !wait_r && bus_hit;
  assign wr_data = bus_req_in.writedata[15:0];

  // Edge detect on the pin, taken as synchronous to clk_in
  assign rise = pin_in && !pin_prev_r;
  assign fall = !pin_in && pin_prev_r;

  always_comb begin
    cap_a = 1'b0;
    cap_b = 1'b0;
    unique case (mode_r)
      `DAC_MODE_PULSE_WIDTH_MEASURE_MODE: begin
        cap_a = polarity_select_r ? fall : rise; // R16
        cap_b = polarity_select_r ? rise : fall; // R16
      end
      `DAC_MODE_IPM, `DAC_MODE_IC: begin
        cap_a = polarity_select_r ? fall : rise; // R17
      end
      default: begin
        cap_a = 1'b0;
        cap_b = 1'b0;
      end
    endcase
  end

  // Force bits live only in the written word; they are never stored
  // Mode before the write decides, so a force beside a mode change is old
  assign force_a = wr_acc && bus_req_in.byteenable[0] && out_mode &&
                   wr_data[`DAC_BIT_FORCE_A]; // R12 R15
  assign force_b = wr_acc && bus_req_in.byteenable[0] && out_mode &&
                   wr_data[`DAC_BIT_FORCE_B]; // R13 R15

  always_comb begin
    flag_set = 1'b0;
    unique case (mode_r)
      `DAC_MODE_PULSE_WIDTH_MEASURE_MODE, `DAC_MODE_IC: flag_set = cap_a; // R2
      `DAC_MODE_IPM: flag_set = cap_a && ipm_first_done_r; // R2
      `DAC_MODE_OCB: flag_set = match_b_in; // R3
      `DAC_MODE_COMPARE_AB_FLAG_MODE: flag_set = match_a_in || match_b_in; // R3
      default: flag_set = mode_r[3] && match_a_in; // R3
    endcase
  end

  // Software clear needs a prior read of one
  assign flag_clr = wr_acc && bus_req_in.byteenable[1] &&
                    !wr_data[`DAC_BIT_FLAG] && flag_read_one_r; // R4

  // Pin status: pin level outside output modes, polarity-adjusted latch in output modes
  assign pin_level = out_ff_r ^ polarity_select_r; // R18
  always_comb begin
    rd_word = 16'h0000;
    rd_word[`DAC_BIT_FLAG] = flag_r;
    rd_word[`DAC_BIT_IL_HI:`DAC_BIT_IL_LO] = interrupt_level_r;
    rd_word[`DAC_BIT_ARB3] = arbitration_msb_r;
    rd_word[`DAC_BIT_WOR] = wired_or_r; // R8
    rd_word[`DAC_BIT_BSL] = bus_select_r;
    rd_word[`DAC_BIT_IN] = out_mode ? pin_level : pin_in; // R10 R11
    rd_word[`DAC_BIT_POL] = polarity_select_r;
    rd_word[`DAC_BIT_MODE_HI:`DAC_BIT_MODE_LO] = mode_r;
  end

  // One wait cycle, then the request completes
  // Back-to-back requests still pay the idle cycle between them
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wait_r <= 1'b1;
    end else if ((bus_req_in.read || bus_req_in.write) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign waitrequest_out = wait_r;

  // Read data are latched as waitrequest drops, unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      readdata_out <= 32'h00000000;
    end else if (bus_req_in.read && wait_r) begin
      readdata_out <= bus_hit ? {16'h0000, rd_word} : 32'h00000000; // R21
    end
  end

  // Control fields, byte lane 1 holds bits 15:8, lane 0 bits 7:0
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      interrupt_level_r <= `DAC_RST_IL; // R21
      arbitration_msb_r <= 1'b0;
      wired_or_r <= 1'b0;
      bus_select_r <= 1'b0;
      polarity_select_r <= 1'b0;
      mode_r <= `DAC_RST_MODE;
    end else if (wr_acc) begin
      if (bus_req_in.byteenable[1]) begin
        interrupt_level_r <= wr_data[`DAC_BIT_IL_HI:`DAC_BIT_IL_LO];
        arbitration_msb_r <= wr_data[`DAC_BIT_ARB3];
        wired_or_r <= wr_data[`DAC_BIT_WOR];
        bus_select_r <= wr_data[`DAC_BIT_BSL];
      end
      if (bus_req_in.byteenable[0]) begin
        polarity_select_r <= wr_data[`DAC_BIT_POL];
        mode_r <= wr_data[`DAC_BIT_MODE_HI:`DAC_BIT_MODE_LO];
      end
    end
  end

  // Event flag: a set in the same cycle as a clear wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_r <= 1'b0; // R4
    end else if (mode_r == `DAC_MODE_DIS) begin
      flag_r <= 1'b0; // R2
    end else if (flag_set) begin
      flag_r <= 1'b1; // R1 R4
    end else if (flag_clr) begin
      flag_r <= 1'b0; // R4
    end
  end

  // Remembers that software saw the flag set
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_read_one_r <= 1'b0;
    end else if (rd_acc) begin
      // Arm from the value software saw, not a flag set meanwhile
      flag_read_one_r <= readdata_out[`DAC_BIT_FLAG];
    end else if (wr_acc && bus_req_in.byteenable[1]) begin
      flag_read_one_r <= 1'b0;
    end
  end

  // First capture in period mode only arms the measurement
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || mode_r != `DAC_MODE_IPM) begin
      ipm_first_done_r <= 1'b0;
    end else if (cap_a) begin
      ipm_first_done_r <= 1'b1; // R2
    end
  end

  // Output flip-flop: A match sets, B match clears
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_ff_r <= 1'b0;
    end else if (force_a && force_b) begin
      out_ff_r <= 1'b0; // R14
    end else if (force_a) begin
      out_ff_r <= 1'b1; // R12
    end else if (force_b) begin
      out_ff_r <= 1'b0; // R13
    end else if (out_mode && match_a_in) begin
      out_ff_r <= 1'b1; // R18
    end else if (out_mode && match_b_in) begin
      out_ff_r <= 1'b0; // R18
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      // Seeded from the pin so release of reset gives no false edge
      pin_prev_r <= pin_in;
    end else begin
      pin_prev_r <= pin_in;
    end
  end

  // Open drain only pulls low, so it releases the pin for a high level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_drive_out <= '0;
    end else begin
      pin_drive_out.pin_o <= is_output_mode(mode_r) ? pin_level : 1'b0;
      pin_drive_out.pin_oe <= out_mode &&
                              (!wired_or_r || !pin_level); // R7
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      capture_a_out <= 1'b0;
      capture_b_out <= 1'b0;
    end else begin
      capture_a_out <= in_mode && cap_a;
      capture_b_out <= in_mode && cap_b;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_select_out <= 1'b0;
    end else begin
      bus_select_out <= bus_select_r; // R9
    end
  end

  // Full resolution while in reset, so no time base bit is lost
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      timebase_mask_out <= 16'hffff;
    end else begin
      timebase_mask_out <= ~ignore_mask; // R19
    end
  end

  // Request follows the flag; a level of zero keeps it quiet
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= '0;
    end else begin
      irq_out.irq <= flag_r && (interrupt_level_r != 3'h0); // R1 R5
      irq_out.level <= flag_r ? interrupt_level_r : 3'h0; // R5
      irq_out.arb_number <= {arbitration_msb_r, arb_low_field_in}; // R6
    end
  end

  // Answer only an acknowledge at exactly our own level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      iack_respond_out <= 1'b0;
    end else begin
      iack_respond_out <= iack_in && flag_r &&
                          (interrupt_level_r != 3'h0) &&
                          (iack_level_in == interrupt_level_r); // R5
    end
  end

endmodule

// File: tb/dac_channel_ctrl_asserts.sv
// Port-level assertions for the channel control block
module dac_channel_ctrl_asserts
  import dac_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire dac_bus_req_type bus_req_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  // Pin, strobes and time base mask
  input wire logic pin_in,
  input wire logic capture_a_out,
  input wire logic capture_b_out,
  input wire logic [15:0] timebase_mask_out,
  // Interrupt side
  input wire logic [2:0] arb_low_field_in,
  input wire logic iack_in,
  input wire logic [2:0] iack_level_in,
  input wire dac_irq_type irq_out,
  input wire logic iack_respond_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_one_wait;
    !waitrequest_out ##1 waitrequest_out;
  endsequence
  property p_ack;
    (bus_req_in.read || bus_req_in.write) && waitrequest_out |=> s_one_wait;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered in one cycle");
  property p_rdz;
    !waitrequest_out |-> readdata_out[31:16] == 16'h0 &&
      readdata_out[10] == 1'b0 && readdata_out[6:5] == 2'h0;
  endproperty
  a_rdz: assert property (p_rdz)
    else $error("zero bits read back nonzero");
  property p_irq;
    irq_out.irq |-> irq_out.level != 3'h0;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request with level zero");
  property p_iack;
    iack_respond_out |-> $past(iack_in) && $past(iack_level_in) != 3'h0;
  endproperty
  a_iack: assert property (p_iack)
    else $error("acknowledge answered without cause");
  property p_arb;
    !$past(sys_rst_in) |->
      irq_out.arb_number[2:0] == $past(arb_low_field_in);
  endproperty
  a_arb: assert property (p_arb)
    else $error("arbitration number low field wrong");
  property p_cap_x;
    !(capture_a_out && capture_b_out);
  endproperty
  a_cap_x: assert property (p_cap_x)
    else $error("both captures on one edge");
  // Edge may sit one or two samples back
  property p_cap_edge;
    capture_a_out || capture_b_out |-> $past(pin_in) != $past(pin_in, 2) ||
      $past(pin_in, 2) != $past(pin_in, 3);
  endproperty
  a_cap_edge: assert property (p_cap_edge)
    else $error("capture without pin edge");
  property p_mask;
    timebase_mask_out[6:0] == 7'h7f &&
      (timebase_mask_out & (timebase_mask_out + 16'h1)) == 16'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("time base mask not a legal resolution");
endmodule

bind dac_channel_ctrl dac_channel_ctrl_asserts dac_channel_ctrl_asserts_inst (
  .clk_in, .sys_rst_in, .bus_req_in, .readdata_out, .waitrequest_out,
  .pin_in, .capture_a_out, .capture_b_out, .timebase_mask_out,
  .arb_low_field_in, .iack_in, .iack_level_in, .irq_out, .iack_respond_out
);

// File: tb/dac_pin_model.sv
// Far-side pin: external source, released line set by ext_lvl_in
module dac_pin_model
  import dac_pkg::*;
(
  // Channel drive
  input wire dac_pin_drive_type drive_in,
  // External level
  input wire logic ext_lvl_in,
  // Resolved pin
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_out = drive_in.pin_oe ? drive_in.pin_o : ext_lvl_in;
endmodule

// File: tb/tb_dac_channel_ctrl.sv
// Register-level tests of the channel control block
module tb_dac_channel_ctrl
  import dac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  dac_bus_req_type bus_req_in = '0;
  logic match_a_in = 1'b0, match_b_in = 1'b0, iack_in = 1'b0, ext = 1'b0;
  logic [2:0] arb_low_field_in = 3'h5, iack_level_in = 3'h3;
  logic [31:0] readdata_out;
  logic waitrequest_out, pin_in, capture_a_out, capture_b_out;
  logic bus_select_out, iack_respond_out;
  logic [15:0] timebase_mask_out, q;
  dac_pin_drive_type pin_drive_out;
  dac_irq_type irq_out;
  int num_errors = 0, comparisons = 0, cycles = 0;
  int cap_a_n = 0, cap_b_n = 0;
  logic [15:0] pwm_mask [8] = '{16'hffff, 16'h7fff, 16'h3fff, 16'h1fff,
    16'h0fff, 16'h07ff, 16'h01ff, 16'h007f};

  dac_channel_ctrl dac_channel_ctrl_inst (.clk_in, .sys_rst_in, .bus_req_in,
    .readdata_out, .waitrequest_out, .pin_in, .pin_drive_out, .match_a_in,
    .match_b_in, .capture_a_out, .capture_b_out, .bus_select_out,
    .timebase_mask_out, .arb_low_field_in, .iack_in, .iack_level_in,
    .irq_out, .iack_respond_out);
  dac_pin_model dac_pin_model_inst (.drive_in(pin_drive_out),
    .ext_lvl_in(ext), .pin_out(pin_in));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cap_a_n += int'(capture_a_out);
    cap_b_n += int'(capture_b_out);
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Idle edge first, so a release never meets the next request
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_req_in <= '{a, !w, w, {16'h0, d}, 4'h3};
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) @(posedge clk_in);
    q = readdata_out[15:0];
    bus_req_in.read <= 1'b0;
    bus_req_in.write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] d);
    xfer(1'b1, 4'h0, d);
  endtask
  task automatic rd(input logic [15:0] exp);
    xfer(1'b0, 4'h0, 16'h0);
    check("reg", q, exp);
  endtask
  task automatic pin_to(input logic v);
    @(posedge clk_in);
    ext <= v;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic hit(input logic a, b);
    @(posedge clk_in);
    match_a_in <= a;
    match_b_in <= b;
    @(posedge clk_in);
    match_a_in <= 1'b0;
    match_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(16'h0000);
    xfer(1'b0, 4'h4, 16'h0);
    check("unmapped", q, 16'h0);
    wr(16'h3ff3);
    rd(16'h3b13);
    check("bsel", {15'h0, bus_select_out}, 16'h1);
    check("arb", {12'h0, irq_out.arb_number}, 16'h000d);
    check("oe", {15'h0, pin_drive_out.pin_oe}, 16'h0);
    $display("test fields done");
    pin_to(1'b1);
    rd(16'h3b93);
    pin_to(1'b0);
    rd(16'hbb13);
    check("irq", {12'h0, irq_out.irq, irq_out.level}, 16'h000b);
    @(posedge clk_in);
    iack_in <= 1'b1;
    @(posedge clk_in);
    iack_in <= 1'b0;
    @(posedge clk_in);
    check("iack", {15'h0, iack_respond_out}, 16'h1);
    wr(16'h3b13);
    rd(16'h3b13);
    check("irq", {12'h0, irq_out.irq, irq_out.level}, 16'h0);
    $display("test capture done");
    wr(16'h3b02);
    pin_to(1'b1);
    rd(16'h3b82);
    pin_to(1'b0);
    pin_to(1'b1);
    rd(16'hbb82);
    wr(16'h3b00);
    rd(16'h3b80);
    wr(16'h3b01);
    pin_to(1'b0);
    rd(16'h3b01);
    pin_to(1'b1);
    rd(16'hbb81);
    wr(16'h0b01);
    wr(16'h3004);
    check("capa", cap_a_n[15:0], 16'h4);
    check("capb", cap_b_n[15:0], 16'h1);
    $display("test measure done");
    wr(16'h3044);
    rd(16'h3084);
    check("pin", {15'h0, pin_drive_out.pin_o}, 16'h1);
    check("oe", {15'h0, pin_drive_out.pin_oe}, 16'h1);
    wr(16'h3064);
    rd(16'h3004);
    hit(1'b1, 1'b0);
    rd(16'h3084);
    hit(1'b0, 1'b1);
    rd(16'hb004);
    wr(16'h3014);
    rd(16'h3094);
    wr(16'h3054);
    rd(16'h3014);
    wr(16'h3234);
    rd(16'h3294);
    check("oe", {15'h0, pin_drive_out.pin_oe}, 16'h0);
    wr(16'h3005);
    hit(1'b1, 1'b0);
    rd(16'hb085);
    wr(16'h3005);
    hit(1'b0, 1'b1);
    rd(16'hb005);
    $display("test output done");
    for (int m = 8; m < 16; m++) begin
      wr({12'h300, m[3:0]});
      repeat (2) @(posedge clk_in);
      check("mask", timebase_mask_out, pwm_mask[m - 8]);
    end
    hit(1'b1, 1'b0);
    rd(16'hb08f);
    wr(16'h3006);
    rd(16'h3086);
    hit(1'b1, 1'b0);
    rd(16'h3086);
    $display("test pwm done");
    print_verdict();
  end
endmodule
